// ==== sesb_bank.sv ====
`timescale 1ns/1ps

// Operation
// R1 - Unmasked low general pin sets its flag
// R2 - Pin flags optionally masked in all sleeps
// R3 - Fan flag sets on slow tachometer; 7:4 reserved
// R4 - Fan flags optional S1/S3, always masked off
// R5 - Host summary set while any host flag set
// R6 - Throttle threshold flags never feed summary
// R7 - Host flags stay set after event ends
// R8 - Writing one clears; writing zero keeps flag
// R9 - Clear fails while condition still present
// R10 - Software reports sleep state; events masked accordingly
// R11 - Starred states mask only when enabled
// R12 - Zone 1/2 flags, optional suspend/off mask
// R13 - Zone 3/4 flags never sleep masked
// R14 - Regulator-hot flags, masked suspend/off; 7:6 reserved
// R15 - Analog limit flags, masked suspend/off
// R16 - Reserved bits zero; flags reset to zero
module sesb_bank (
    input  wire logic                     I_MCLK,
    input  wire logic                     I_RESETN,
    input  wire sesb_pkg::sesb_req_t      I_REG_REQ,
    input  wire logic [7:0]               I_GENERAL_PIN,
    input  wire logic [7:0]               I_PIN_FAULT_MASK,
    input  wire logic [1:0]               I_REGULATOR_HOT_INPUT,
    input  wire logic [3:0]               I_FAN_SLOW,
    input  wire logic [3:0]               I_ZONE_LIMIT,
    input  wire logic [7:0]               I_ANALOG_LIMIT,
    input  wire sesb_pkg::sesb_sleep_t    I_SLEEP_STATE,
    input  wire sesb_pkg::sesb_slp_mask_t I_SLEEP_MASK,
    output logic [7:0]                    O_REG_RDATA,
    output logic                          O_REG_RVALID,
    output logic                          O_HOST_ERR
);
    import sesb_pkg::*;

    // True when the current sleep state blocks an event class
    function automatic logic sleep_blocks(input sesb_sleep_t st,
                                          input logic in_light,
                                          input logic in_suspend,
                                          input logic in_off);
        logic blk;
        blk = 1'b0;
        case (st)
            SLP_LIGHT:   blk = in_light;
            SLP_SUSPEND: blk = in_suspend;
            SLP_OFF:     blk = in_off;
            default:     blk = 1'b0;
        endcase
        return blk;
    endfunction

    logic [NUM_SYNC-1:0] sync1_q;
    logic [NUM_SYNC-1:0] sync2_q;
    logic [NUM_SYNC-1:0] sync3_q;
    logic [NUM_SYNC-1:0] lvl_q;
    logic [NUM_SYNC-1:0] pin_raw;
    logic [7:0]          flag_q   [NUM_REGS];
    logic [7:0]          flag_d   [NUM_REGS];
    logic [7:0]          event_w  [NUM_REGS];
    logic [7:0]          clear_w  [NUM_REGS];
    logic [7:0]          valid_w  [NUM_REGS];
    logic [7:0]          offset_w [NUM_REGS];
    logic [7:0]          rdata_d;
    logic                pin_blk;
    logic                fan_blk;
    logic                zone_blk;
    logic                hot_blk;
    logic                host_err_d;

    assign pin_raw = {I_REGULATOR_HOT_INPUT, I_GENERAL_PIN};

    // Three-stage capture; a level counts once stages two and three agree
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
            sync3_q <= SYNC_RESET;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    generate
        for (genvar s = 0; s < NUM_SYNC; s++) begin : g_lvl
            always_ff @(posedge I_MCLK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    lvl_q[s] <= SYNC_RESET[s];
                end else if (sync2_q[s] == sync3_q[s]) begin
                    lvl_q[s] <= sync3_q[s];
                end
            end
        end
    endgenerate

    // Sleep masking from the software-reported state
    assign pin_blk  = sleep_blocks(I_SLEEP_STATE, I_SLEEP_MASK.pin_light,
                                   I_SLEEP_MASK.pin_suspend,
                                   I_SLEEP_MASK.pin_off); // R2 R10 R11
    assign fan_blk  = sleep_blocks(I_SLEEP_STATE, I_SLEEP_MASK.fan_light,
                                   I_SLEEP_MASK.fan_suspend,
                                   1'b1); // R4 R11
    assign zone_blk = sleep_blocks(I_SLEEP_STATE, 1'b0,
                                   I_SLEEP_MASK.zone_suspend,
                                   I_SLEEP_MASK.zone_off); // R12 R11
    assign hot_blk  = sleep_blocks(I_SLEEP_STATE, 1'b0, 1'b1, 1'b1); // R14 R15

    assign event_w[0] = ~lvl_q[PIN_LO +: 8] & ~I_PIN_FAULT_MASK
                        & {8{~pin_blk}}; // R1
    assign event_w[1] = {4'h0, I_FAN_SLOW & {4{~fan_blk}}}; // R3
    assign event_w[2] = {2'b00,
                         lvl_q[HOT_LO +: 2] & {2{~hot_blk}}, // R14
                         I_ZONE_LIMIT[3:2], // R13
                         I_ZONE_LIMIT[1:0] & {2{~zone_blk}}}; // R12
    assign event_w[3] = I_ANALOG_LIMIT & {8{~hot_blk}}; // R15

    assign offset_w[0] = PIN_FAULT_OFS;
    assign offset_w[1] = FAN_FAULT_OFS;
    assign offset_w[2] = HOST_ZONE_OFS;
    assign offset_w[3] = HOST_ANLG_OFS;
    assign valid_w[0]  = PIN_FAULT_VALID;
    assign valid_w[1]  = FAN_FAULT_VALID;
    assign valid_w[2]  = HOST_ZONE_VALID;
    assign valid_w[3]  = HOST_ANLG_VALID;

    generate
        for (genvar r = 0; r < NUM_REGS; r++) begin : g_flag
            assign clear_w[r] = (I_REG_REQ.wr && I_REG_REQ.addr == offset_w[r])
                                ? I_REG_REQ.wdata : 8'h00; // R8
            // Event term last, so a set in the clearing cycle wins
            assign flag_d[r] = ((flag_q[r] & ~clear_w[r]) | event_w[r])
                               & valid_w[r]; // R7 R9 R16
            always_ff @(posedge I_MCLK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    flag_q[r] <= FLAGS_RESET; // R16
                end else begin
                    flag_q[r] <= flag_d[r];
                end
            end
        end
    endgenerate

    // Only the two host registers here; no throttle input reaches the summary
    assign host_err_d = (|flag_d[2]) | (|flag_d[3]); // R5 R6

    always_comb begin
        rdata_d = UNMAPPED_DATA;
        case (I_REG_REQ.addr)
            PIN_FAULT_OFS: rdata_d = flag_q[0];
            FAN_FAULT_OFS: rdata_d = flag_q[1];
            HOST_ZONE_OFS: rdata_d = flag_q[2];
            HOST_ANLG_OFS: rdata_d = flag_q[3];
            default:       rdata_d = UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_REG_RDATA  <= UNMAPPED_DATA;
            O_REG_RVALID <= 1'b0;
            O_HOST_ERR   <= 1'b0;
        end else begin
            O_REG_RDATA  <= I_REG_REQ.rd ? rdata_d : UNMAPPED_DATA;
            O_REG_RVALID <= I_REG_REQ.rd;
            O_HOST_ERR   <= host_err_d;
        end
    end

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RESETN);

    a_pin_low_sets: assert property ( // R1
        (|event_w[0])
        |=> ((flag_q[0] & $past(event_w[0])) == $past(event_w[0])))
        else $error("pin fault flag did not set");

    a_pin_sleep_mask: assert property ( // R2
        (I_SLEEP_STATE == SLP_SUSPEND && I_SLEEP_MASK.pin_suspend)
        |-> event_w[0] == 8'h00)
        else $error("pin event passed while masked in suspend");

    a_fan_reserved: assert property ( // R3
        (I_REG_REQ.rd && I_REG_REQ.addr == FAN_FAULT_OFS)
        |=> O_REG_RDATA[7:4] == 4'h0)
        else $error("fan reserved bits read nonzero");

    a_fan_off_masked: assert property ( // R4
        (I_SLEEP_STATE == SLP_OFF && I_FAN_SLOW != 4'h0
         && flag_q[1] == 8'h00) |=> flag_q[1] == 8'h00)
        else $error("fan flag set in off state");

    a_host_summary: assert property ( // R5
        ##1 O_HOST_ERR == ((|flag_q[2]) | (|flag_q[3])))
        else $error("host summary disagrees with host flags");

    a_flag_sticky: assert property ( // R7
        !(I_REG_REQ.wr && I_REG_REQ.addr == HOST_ANLG_OFS)
        |=> (flag_q[3] & $past(flag_q[3])) == $past(flag_q[3]))
        else $error("host flag dropped without a clear");

    a_w1c_clears: assert property ( // R8
        (I_REG_REQ.wr && I_REG_REQ.addr == HOST_ANLG_OFS
         && event_w[3] == 8'h00)
        |=> flag_q[3] == ($past(flag_q[3]) & ~$past(I_REG_REQ.wdata)))
        else $error("write-one-to-clear misbehaved");

    a_clear_blocked: assert property ( // R9
        (I_REG_REQ.wr && I_REG_REQ.addr == HOST_ZONE_OFS
         && (event_w[2] & I_REG_REQ.wdata) != 8'h00)
        |=> (flag_q[2] & $past(event_w[2])) == $past(event_w[2]))
        else $error("flag cleared while condition present");

    a_zone_unmasked: assert property ( // R13
        (I_ZONE_LIMIT[3:2] == 2'b11) |=> flag_q[2][3:2] == 2'b11)
        else $error("zone 3/4 flags were masked");

    a_hot_suspend: assert property ( // R15
        (I_SLEEP_STATE == SLP_SUSPEND || I_SLEEP_STATE == SLP_OFF)
        |-> (event_w[3] == 8'h00 && event_w[2][5:4] == 2'b00))
        else $error("regulator or analog event passed in deep sleep");

    a_pin_mask_holds: assert property ( // R1
        (I_PIN_FAULT_MASK != 8'h00)
        |=> (flag_q[0] & $past(I_PIN_FAULT_MASK) & ~$past(flag_q[0]))
            == 8'h00)
        else $error("masked pin raised its flag");

    a_pin_light_off: assert property ( // R2
        (I_SLEEP_STATE == SLP_LIGHT && I_SLEEP_MASK.pin_light)
        || (I_SLEEP_STATE == SLP_OFF && I_SLEEP_MASK.pin_off)
        |-> event_w[0] == 8'h00)
        else $error("pin event passed while masked in sleep");

    a_fan_slow_sets: assert property ( // R3
        (I_FAN_SLOW != 4'h0 && I_SLEEP_STATE == SLP_AWAKE)
        |=> (flag_q[1][3:0] & $past(I_FAN_SLOW)) == $past(I_FAN_SLOW))
        else $error("slow fan did not raise its flag");

    a_fan_upper_zero: assert property ( // R3
        flag_q[1][7:4] == 4'h0)
        else $error("fan reserved flag bits set");

    a_zone_upper_zero: assert property ( // R14
        flag_q[2][7:6] == 2'b00)
        else $error("zone register reserved bits set");

    a_fan_light_mask: assert property ( // R4
        (I_SLEEP_STATE == SLP_LIGHT && I_SLEEP_MASK.fan_light
         && flag_q[1] == 8'h00) |=> flag_q[1] == 8'h00)
        else $error("fan flag set while masked in light sleep");

    a_summary_host_only: assert property ( // R6
        (flag_q[2] == 8'h00 && flag_q[3] == 8'h00) |-> !O_HOST_ERR)
        else $error("summary raised by a non-host flag");

    a_zone_sticky: assert property ( // R7
        !(I_REG_REQ.wr && I_REG_REQ.addr == HOST_ZONE_OFS)
        |=> (flag_q[2] & $past(flag_q[2])) == $past(flag_q[2]))
        else $error("zone flag dropped without a clear");

    a_pin_w1c: assert property ( // R8
        (I_REG_REQ.wr && I_REG_REQ.addr == PIN_FAULT_OFS
         && event_w[0] == 8'h00)
        |=> flag_q[0] == ($past(flag_q[0]) & ~$past(I_REG_REQ.wdata)))
        else $error("pin flag write-one-to-clear misbehaved");

    a_zone_opt_clear: assert property ( // R11
        (I_SLEEP_STATE == SLP_SUSPEND && !I_SLEEP_MASK.zone_suspend
         && I_ZONE_LIMIT[1:0] == 2'b11) |=> flag_q[2][1:0] == 2'b11)
        else $error("zone 1/2 masked although its enable is off");

    a_zone_sets: assert property ( // R12
        (I_SLEEP_STATE == SLP_AWAKE && I_ZONE_LIMIT[1:0] != 2'b00)
        |=> (flag_q[2][1:0] & $past(I_ZONE_LIMIT[1:0]))
            == $past(I_ZONE_LIMIT[1:0]))
        else $error("zone 1/2 limit did not raise its flag");

    a_hot_sets: assert property ( // R14
        (I_SLEEP_STATE == SLP_AWAKE && lvl_q[HOT_LO +: 2] != 2'b00)
        |=> (flag_q[2][5:4] & $past(lvl_q[HOT_LO +: 2]))
            == $past(lvl_q[HOT_LO +: 2]))
        else $error("regulator-hot did not raise its flag");

    a_analog_sets: assert property ( // R15
        (I_SLEEP_STATE == SLP_LIGHT && I_ANALOG_LIMIT != 8'h00)
        |=> (flag_q[3] & $past(I_ANALOG_LIMIT)) == $past(I_ANALOG_LIMIT))
        else $error("analog limit did not raise its flag in light sleep");

    a_awake_analog: assert property ( // R10
        (I_SLEEP_STATE == SLP_AWAKE && I_ANALOG_LIMIT != 8'h00)
        |=> (flag_q[3] & $past(I_ANALOG_LIMIT)) == $past(I_ANALOG_LIMIT))
        else $error("analog limit did not raise its flag while awake");

    c_clear_race: cover property (
        I_REG_REQ.wr && I_REG_REQ.addr == HOST_ZONE_OFS && |event_w[2]);
    c_summary_rise: cover property ($rose(O_HOST_ERR));
    c_pin_flag: cover property (##1 $rose(flag_q[0][7]));
    c_off_fan_slow: cover property (
        I_SLEEP_STATE == SLP_OFF && I_FAN_SLOW != 4'h0);
    c_pin_mask_used: cover property (
        (|I_PIN_FAULT_MASK) && (|event_w[0]));

endmodule

// ==== sesb_pkg.sv ====
package sesb_pkg;

    localparam int unsigned REG_W     = 8;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned NUM_REGS  = 4;
    localparam int unsigned NUM_SYNC  = 10;

    // Register offsets on the management port
    localparam logic [7:0] PIN_FAULT_OFS  = 8'h46;
    localparam logic [7:0] FAN_FAULT_OFS  = 8'h47;
    localparam logic [7:0] HOST_ZONE_OFS  = 8'h48;
    localparam logic [7:0] HOST_ANLG_OFS  = 8'h49;

    // Implemented bits; the rest are reserved and read zero
    localparam logic [7:0] PIN_FAULT_VALID = 8'hFF;
    localparam logic [7:0] FAN_FAULT_VALID = 8'h0F;
    localparam logic [7:0] HOST_ZONE_VALID = 8'h3F;
    localparam logic [7:0] HOST_ANLG_VALID = 8'hFF;

    localparam logic [7:0] FLAGS_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

    // Pins idle high, regulator-hot idles low
    localparam logic [9:0] SYNC_RESET      = 10'h0FF;
    localparam int unsigned PIN_LO         = 0;
    localparam int unsigned HOT_LO         = 8;

    typedef enum logic [1:0] {
        SLP_AWAKE,
        SLP_LIGHT,
        SLP_SUSPEND,
        SLP_OFF
    } sesb_sleep_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } sesb_req_t;

    // Optional sleep-state mask enables
    typedef struct packed {
        logic pin_light;
        logic pin_suspend;
        logic pin_off;
        logic fan_light;
        logic fan_suspend;
        logic zone_suspend;
        logic zone_off;
    } sesb_slp_mask_t;

endpackage

// ==== sesb_host.sv ====
`timescale 1ns/1ps

module sesb_host (
    input  wire logic           i_clk,
    input  wire logic [7:0]     i_rdata,
    input  wire logic           i_rvalid,
    output sesb_pkg::sesb_req_t o_req
);
    import sesb_pkg::*;

    initial o_req = '0;

    // Released fields go inverted so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
        d = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
    endtask
endmodule

// ==== sesb_bank_bench.sv ====
`timescale 1ns/1ps

module sesb_bank_bench;
    import sesb_pkg::*;

    logic           mclk, resetn, hst, rvalid;
    sesb_req_t      req;
    logic [7:0]     pin, pmask, an, rdata;
    logic [1:0]     hot;
    logic [3:0]     fan, zone;
    sesb_sleep_t    st;
    sesb_slp_mask_t sm;
    int             bad_count, compares, tn;

    always #2 mclk = ~mclk;

    sesb_bank dut (
        .I_MCLK(mclk), .I_RESETN(resetn), .I_REG_REQ(req),
        .I_GENERAL_PIN(pin), .I_PIN_FAULT_MASK(pmask),
        .I_REGULATOR_HOT_INPUT(hot), .I_FAN_SLOW(fan),
        .I_ZONE_LIMIT(zone), .I_ANALOG_LIMIT(an),
        .I_SLEEP_STATE(st), .I_SLEEP_MASK(sm),
        .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_HOST_ERR(hst));

    sesb_host host (.i_clk(mclk), .i_rdata(rdata), .i_rvalid(rvalid),
                    .o_req(req));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask

    // Pin argument gives faulting pins; pins idle high
    task automatic ev(input logic [7:0] p, input logic [1:0] h,
                      input logic [3:0] f, input logic [3:0] z,
                      input logic [7:0] a);
        @(negedge mclk);
        pin = ~p;
        hot = h;
        fan = f;
        zone = z;
        an = a;
        repeat (6) @(negedge mclk);
        pin = 8'hFF;
        hot = 2'b00;
        fan = 4'h0;
        zone = 4'h0;
        an = 8'h00;
    endtask

    task automatic clr_all();
        for (int i = 0; i < 4; i++) host.wr(PIN_FAULT_OFS + 8'(i), 8'hFF);
    endtask

    task automatic done();
        $display("test %0d done", tn);
        tn++;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        mclk = 0;
        resetn = 0;
        pin = 8'hFF;
        pmask = 8'h00;
        hot = 2'b00;
        fan = 4'h0;
        zone = 4'h0;
        an = 8'h00;
        st = SLP_AWAKE;
        sm = '0;
        bad_count = 0;
        compares = 0;
        tn = 1;
        repeat (2) @(negedge mclk);
        resetn = 1;
        for (int i = 0; i < 4; i++) rchk(PIN_FAULT_OFS + 8'(i), 8'h00);
        rchk(8'h50, UNMAPPED_DATA);
        chk({7'h0, hst}, 8'h00);
        done();
        ev(8'h00, 2'b11, 4'h0, 4'hF, 8'h00);
        rchk(HOST_ZONE_OFS, 8'h3F);
        chk({7'h0, hst}, 8'h01);
        host.wr(HOST_ZONE_OFS, 8'h00);
        rchk(HOST_ZONE_OFS, 8'h3F);
        host.wr(HOST_ZONE_OFS, 8'hFF);
        rchk(HOST_ZONE_OFS, 8'h00);
        chk({7'h0, hst}, 8'h00);
        done();
        zone = 4'h4;
        host.wr(HOST_ZONE_OFS, 8'hFF);
        rchk(HOST_ZONE_OFS, 8'h04);
        zone = 4'h0;
        host.wr(HOST_ZONE_OFS, 8'h04);
        rchk(HOST_ZONE_OFS, 8'h00);
        done();
        pmask = 8'h03;
        ev(8'h0F, 2'b00, 4'hF, 4'h0, 8'h00);
        chk({7'h0, hst}, 8'h00);
        ev(8'h00, 2'b00, 4'h0, 4'h0, 8'hFF);
        rchk(PIN_FAULT_OFS, 8'h0C);
        rchk(FAN_FAULT_OFS, 8'h0F);
        rchk(HOST_ANLG_OFS, 8'hFF);
        clr_all();
        rchk(HOST_ANLG_OFS, 8'h00);
        done();
        pmask = 8'h00;
        for (int s = 1; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                st = sesb_sleep_t'(s);
                sm = (m != 0) ? '1 : '0;
                ev(8'hFF, 2'b11, 4'hF, 4'hF, 8'hFF);
                rchk(PIN_FAULT_OFS, (m != 0) ? 8'h00 : 8'hFF);
                rchk(FAN_FAULT_OFS, (m != 0 || s == 3) ? 8'h00 : 8'h0F);
                rchk(HOST_ZONE_OFS, (s == 1) ? 8'h3F
                                    : ((m != 0) ? 8'h0C : 8'h0F));
                rchk(HOST_ANLG_OFS, (s == 1) ? 8'hFF : 8'h00);
                st = SLP_AWAKE;
                clr_all();
            end
        end
        done();
        ev(8'h01, 2'b00, 4'h1, 4'h1, 8'h01);
        chk({7'h0, hst}, 8'h01);
        resetn = 0;
        repeat (2) @(negedge mclk);
        resetn = 1;
        for (int i = 0; i < 4; i++) rchk(PIN_FAULT_OFS + 8'(i), 8'h00);
        chk({7'h0, hst}, 8'h00);
        done();
        end_of_test();
    end

    // Tests need a few hundred cycles; allow ample margin
    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
endmodule
